// ===== rco_divider.sv
// clock divider core: toggles its output every ratio source edges, or follows the source level when ratio is zero
// assumes tick is a one-cycle pulse on each rising source edge
`timescale 1ns/1ps
`default_nettype none
module rco_divider #(
  parameter int DIV_W = 15
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic srcLevel,
  input wire logic [DIV_W-1:0] ratio,
  input wire logic loadReq,
  // results
  output logic clkOut,
  output logic loadAck
);
  logic [DIV_W-1:0] curRatio;
  logic [DIV_W-1:0] count;
  logic bypass;
  logic wrapNow;

  assign bypass = (curRatio == '0);
  assign wrapNow = tick && (count == curRatio - 1'b1);
  // new ratio only at a clean boundary, so no runt phase
  assign loadAck = loadReq && (!run || bypass || wrapNow);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      curRatio <= '0;
      count <= '0;
      clkOut <= 1'b0;
    end else begin
      if (loadAck) begin
        curRatio <= ratio;
      end
      if (!run) begin
        count <= '0;
        clkOut <= 1'b0;
      end else if (bypass) begin
        count <= '0;
        clkOut <= srcLevel;
      end else if (wrapNow) begin
        count <= '0;
        clkOut <= !clkOut;
      end else if (tick) begin
        count <= count + 1'b1;
      end
    end
  end

  property p_bypass_follow;
    @(posedge clock) disable iff (!rst_b)
      (run && bypass && !loadAck) |=> (clkOut == $past(srcLevel));
  endproperty
  a_bypass_follow: assert property (p_bypass_follow)
    else $error("undivided output does not follow source");

  property p_div_toggle;
    @(posedge clock) disable iff (!rst_b)
      (run && !bypass && wrapNow) |=> (clkOut != $past(clkOut)) && (count == '0);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("divided output missed its toggle");

  property p_div_bound;
    @(posedge clock) disable iff (!rst_b)
      (run && !bypass) |-> (count < curRatio);
  endproperty
  a_div_bound: assert property (p_div_bound)
    else $error("divider count beyond ratio");
endmodule
`default_nettype wire

// ===== rco_pkg.sv
// constants for the reference clock output generator
// assumes a 32-bit AXI4-Lite register bus and one system clock
package rco_pkg;
  // register map
  localparam logic [7:0] RCO_CTRL_OFFSET = 8'h00;
  localparam logic [31:0] RCO_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RCO_WRITE_MASK = 32'h7FFF_BA0F;
  localparam logic [31:0] RCO_RSVD_MASK = 32'h8000_44F0;
  // field positions
  localparam int RCO_DIV_LSB = 16;
  localparam int RCO_DIV_W = 15;
  localparam int RCO_ON_BIT = 15;
  localparam int RCO_IDLE_BIT = 13;
  localparam int RCO_OE_BIT = 12;
  localparam int RCO_SLP_BIT = 11;
  localparam int RCO_PEND_BIT = 9;
  localparam int RCO_ACT_BIT = 8;
  localparam int RCO_SRC_LSB = 0;
  localparam int RCO_SRC_W = 4;
  localparam int RCO_NUM_SRC = 16;
  localparam logic [3:0] RCO_SRC_SYSCLK = 4'h0;
  // bus responses
  localparam logic [1:0] RCO_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCO_RESP_SLVERR = 2'h2;
endpackage

// ===== rco_ref_clock_top.sv
// reference clock output generator with one AXI4-Lite control register
// assumes idle and sleep flags come from the same clock domain;
// the external source clocks are asynchronous and are synchronised here
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rco_ref_clock_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power modes
  input wire logic idleMode,
  input wire logic sleepMode,
  // source clocks, index 0 unused (system clock)
  input wire logic [rco_pkg::RCO_NUM_SRC-1:0] srcClockIn,
  // generated clock
  output logic genClock,
  output logic refClockOutO,
  output logic refClockOutOe_b
);
  localparam int NSRC = rco_pkg::RCO_NUM_SRC;
  localparam int DW = rco_pkg::RCO_DIV_W;

  // control fields
  logic [DW-1:0] ctrlDiv;
  logic ctrlOn;
  logic ctrlIdleHalt;
  logic ctrlOe;
  logic ctrlSleepRun;
  logic ctrlDivPending;
  logic ctrlActive;
  logic [rco_pkg::RCO_SRC_W-1:0] ctrlSrc;

  // bus state
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // source path
  logic [NSRC-1:1] srcSync1;
  logic [NSRC-1:1] srcSync2;
  logic [NSRC-1:1] srcSync3;
  logic sysToggle;
  logic divClk;
  logic loadAck;

  // decode and selection
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire wrHit = (awAddr == ADDR_W'(rco_pkg::RCO_CTRL_OFFSET));
  wire regWr = doWrite && wrHit;
  wire rdHit = (s_axi_araddr == ADDR_W'(rco_pkg::RCO_CTRL_OFFSET));
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire [31:0] byteMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  wire [31:0] wrEn = byteMask & rco_pkg::RCO_WRITE_MASK;
  wire [31:0] curWord = {1'b0, ctrlDiv, ctrlOn, 1'b0, ctrlIdleHalt, ctrlOe, ctrlSleepRun,
                         1'b0, ctrlDivPending, ctrlActive, 4'h0, ctrlSrc};
  wire [31:0] newWord = (curWord & ~wrEn) | (wData & wrEn);
  wire pendSet = regWr && wStrb[1] && wData[rco_pkg::RCO_PEND_BIT];
  wire srcIsSys = (ctrlSrc == rco_pkg::RCO_SRC_SYSCLK);
  wire idleStop = idleMode && ctrlIdleHalt;
  // sleep stop unless run-in-sleep on a non-system source
  wire sleepStop = sleepMode && !(ctrlSleepRun && !srcIsSys);
  wire runGen = ctrlOn && !idleStop && !sleepStop;
  wire [NSRC-1:0] levelVec = {srcSync2, sysToggle};
  wire [NSRC-1:0] edgeVec = {srcSync2 & ~srcSync3, 1'b1};
  wire selLevel = levelVec[ctrlSrc];
  wire selTick = edgeVec[ctrlSrc];

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write channels, taken in either order
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rco_pkg::RCO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? rco_pkg::RCO_RESP_OKAY : rco_pkg::RCO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, one cycle to answer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rco_pkg::RCO_RESP_OKAY;
    end else if (rdTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdHit ? (curWord & ~rco_pkg::RCO_RSVD_MASK) : 32'h0000_0000;
      s_axi_rresp <= rdHit ? rco_pkg::RCO_RESP_OKAY : rco_pkg::RCO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control register; writes while enable and active differ are not guarded
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrlDiv <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_DIV_LSB +: DW];
      ctrlOn <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_ON_BIT];
      ctrlIdleHalt <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_IDLE_BIT];
      ctrlOe <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_OE_BIT];
      ctrlSleepRun <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_SLP_BIT];
      ctrlSrc <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_SRC_LSB +: rco_pkg::RCO_SRC_W];
    end else if (regWr) begin
      ctrlDiv <= newWord[rco_pkg::RCO_DIV_LSB +: DW];
      ctrlOn <= newWord[rco_pkg::RCO_ON_BIT];
      ctrlIdleHalt <= newWord[rco_pkg::RCO_IDLE_BIT];
      ctrlOe <= newWord[rco_pkg::RCO_OE_BIT];
      ctrlSleepRun <= newWord[rco_pkg::RCO_SLP_BIT];
      ctrlSrc <= newWord[rco_pkg::RCO_SRC_LSB +: rco_pkg::RCO_SRC_W];
    end
  end

  // status bits: pending set by a bus write and cleared by hardware, active set and cleared by hardware
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrlDivPending <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_PEND_BIT];
      ctrlActive <= rco_pkg::RCO_CTRL_RESET[rco_pkg::RCO_ACT_BIT];
    end else begin
      if (pendSet) begin
        ctrlDivPending <= 1'b1;
      end else if (loadAck) begin
        ctrlDivPending <= 1'b0;
      end
      // active drops once output parked low
      if (ctrlOn) begin
        ctrlActive <= 1'b1;
      end else if (!divClk) begin
        ctrlActive <= 1'b0;
      end
    end
  end

  // source synchronisers; stage one feeds only stage two
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      srcSync1 <= '0;
      srcSync2 <= '0;
      srcSync3 <= '0;
      sysToggle <= 1'b0;
    end else begin
      srcSync1 <= srcClockIn[NSRC-1:1];
      srcSync2 <= srcSync1;
      srcSync3 <= srcSync2;
      sysToggle <= !sysToggle;
    end
  end

  rco_divider #(
    .DIV_W(DW)
  ) u_divider (
    .clock(clock),
    .rst_b(rst_b),
    .run(runGen),
    .tick(selTick),
    .srcLevel(selLevel),
    .ratio(ctrlDiv),
    .loadReq(ctrlDivPending),
    .clkOut(divClk),
    .loadAck(loadAck)
  );

  assign genClock = divClk;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      refClockOutO <= 1'b0;
      refClockOutOe_b <= 1'b1;
    end else begin
      refClockOutO <= ctrlOe ? divClk : 1'b0;
      refClockOutOe_b <= !ctrlOe;
    end
  end

  property p_rsvd_zero;
    @(posedge clock) disable iff (!rst_b)
      s_axi_rvalid |-> ((s_axi_rdata & rco_pkg::RCO_RSVD_MASK) == 32'h0000_0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_off_stops;
    @(posedge clock) disable iff (!rst_b)
      (!ctrlOn) [*2] |-> !genClock;
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("clock runs while disabled");

  property p_idle_halt;
    @(posedge clock) disable iff (!rst_b)
      (idleMode && ctrlIdleHalt) [*2] |-> !genClock;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("clock runs in idle with halt set");

  property p_pin_drive;
    @(posedge clock) disable iff (!rst_b)
      ##1 (refClockOutOe_b == !$past(ctrlOe)) && (refClockOutO == ($past(ctrlOe) && $past(genClock)));
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("pin drive does not follow output enable");

  property p_sleep_off;
    @(posedge clock) disable iff (!rst_b)
      (sleepMode && !ctrlSleepRun) [*2] |-> !genClock;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("clock runs in sleep without run-in-sleep");

  property p_sleep_sys;
    @(posedge clock) disable iff (!rst_b)
      (sleepMode && srcIsSys) [*2] |-> !genClock;
  endproperty
  a_sleep_sys: assert property (p_sleep_sys)
    else $error("run-in-sleep honoured for source zero");

  property p_pend_clear;
    @(posedge clock) disable iff (!rst_b)
      (ctrlDivPending && loadAck && !pendSet) |=> !ctrlDivPending;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending flag not cleared after switch");

  property p_active_track;
    @(posedge clock) disable iff (!rst_b)
      (ctrlOn |=> ctrlActive) and ($fell(ctrlActive) |-> !$past(ctrlOn) && !$past(divClk));
  endproperty
  a_active_track: assert property (p_active_track)
    else $error("active status does not track request");

  property p_pend_hold;
    @(posedge clock) disable iff (!rst_b)
      (ctrlDivPending && !loadAck) |=> ctrlDivPending;
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending flag dropped before switch");

  property p_active_off;
    @(posedge clock) disable iff (!rst_b)
      (!ctrlOn && !divClk) |=> !ctrlActive;
  endproperty
  a_active_off: assert property (p_active_off)
    else $error("active status held after stop");
endmodule
`default_nettype wire

// ===== rco_ref_clock_top_tb.sv
// self-checking bench for the reference clock generator top
// assumes rco_pkg and the design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module rco_ref_clock_top_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0, rData, rd;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, genClock, pinO, pinOe_b;
  logic [1:0] bResp, rResp, rsp;
  logic idleMode = 1'b0, sleepMode = 1'b0;
  logic [15:0] srcClockIn = 16'h0000;
  logic [2:0] srcCnt = 3'h0;
  logic srcRun = 1'b1;
  int numErrors = 0, checksDone = 0, cycles = 0, cnt;

  always #4 clock = ~clock;

  // source 1 runs at one eighth of the system clock; srcRun low freezes it
  always @(posedge clock) begin
    srcCnt <= srcCnt + 3'h1;
    srcClockIn <= {14'h0000, srcCnt[2] & srcRun, 1'b0};
  end

  rco_ref_clock_top #(.ADDR_W(8)) DUT (
    .clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .idleMode(idleMode), .sleepMode(sleepMode), .srcClockIn(srcClockIn),
    .genClock(genClock), .refClockOutO(pinO), .refClockOutOe_b(pinOe_b)
  );

  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hung handshake ends here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      results;
    end
  end

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // handshakes are judged at the falling edge, inputs only move at the rising one
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    @(posedge clock);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(negedge clock);
      aw = awValid & awReady;
      w = wValid & wReady;
      b = bValid;
      rsp = bResp;
      @(posedge clock);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
    end while (!b);
    bReady <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a);
    logic ar, r;
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(negedge clock);
      ar = arValid & arReady;
      r = rValid;
      rd = rData;
      rsp = rResp;
      @(posedge clock);
      if (ar) arValid <= 1'b0;
    end while (!r);
    rReady <= 1'b0;
  endtask

  // polling keeps writes away from an enable/active mismatch
  task automatic waitBit(input int pos, input logic v);
    for (int i = 0; i < 20; i++) begin
      axiRead(8'h00);
      if (rd[pos] === v) break;
    end
    checkWord("status bit", {31'h0, v}, {31'h0, rd[pos]});
  endtask

  task automatic countToggles(input int n);
    logic prev;
    cnt = 0;
    @(negedge clock);
    prev = genClock;
    repeat (n) begin
      @(negedge clock);
      if (genClock !== prev) cnt++;
      prev = genClock;
    end
  endtask

  task automatic checkRuns(input string what, input logic exp);
    // a mode change needs two edges to reach the output
    repeat (3) @(posedge clock);
    countToggles(60);
    checkWord(what, {31'h0, exp}, {31'h0, cnt > 0});
  endtask

  task automatic highLen;
    @(negedge clock);
    for (int i = 0; i < 200 && genClock !== 1'b0; i++) @(negedge clock);
    for (int i = 0; i < 200 && genClock !== 1'b1; i++) @(negedge clock);
    cnt = 0;
    while (genClock === 1'b1 && cnt < 200) begin
      @(negedge clock);
      cnt++;
    end
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    checkWord("pin enable", 32'h1, {31'h0, pinOe_b});
    axiRead(8'h00);
    checkWord("reset value", rco_pkg::RCO_CTRL_RESET, rd);
    checkWord("read resp", {30'h0, rco_pkg::RCO_RESP_OKAY}, {30'h0, rsp});
    axiWrite(8'h00, 32'hFFFF_7DFF, 4'hF);
    checkWord("write resp", {30'h0, rco_pkg::RCO_RESP_OKAY}, {30'h0, rsp});
    axiRead(8'h00);
    checkWord("all fields", 32'h7FFF_380F, rd);
    axiWrite(8'h00, 32'h0, 4'h1);
    axiRead(8'h00);
    checkWord("byte lane", 32'h7FFF_3800, rd);
    axiWrite(8'h00, 32'h0, 4'hF);
    axiWrite(8'h04, 32'hFFFF_FFFF, 4'hF);
    checkWord("unmapped resp", {30'h0, rco_pkg::RCO_RESP_SLVERR}, {30'h0, rsp});
    axiRead(8'h04);
    checkWord("unmapped data", 32'h0, rd);
    checkWord("unmapped rresp", {30'h0, rco_pkg::RCO_RESP_SLVERR}, {30'h0, rsp});
    axiRead(8'h00);
    checkWord("after unmapped", 32'h0, rd);
    $display("test registers done");
    axiWrite(8'h00, 32'h0000_9000, 4'hF);
    waitBit(8, 1'b1);
    highLen;
    checkWord("undivided high", 32'h1, 32'(cnt));
    repeat (8) begin
      @(negedge clock);
      rsp[0] = genClock;
      @(negedge clock);
      checkWord("pin data", {31'h0, rsp[0]}, {31'h0, pinO});
    end
    checkWord("pin driven", 32'h0, {31'h0, pinOe_b});
    axiWrite(8'h00, 32'h0000_8000, 4'hF);
    repeat (3) @(negedge clock);
    checkWord("pin released", 32'h1, {31'h0, pinOe_b});
    axiRead(8'h00);
    checkWord("active read", 32'h0000_8100, rd);
    axiWrite(8'h00, 32'h0000_0100, 4'hF);
    waitBit(8, 1'b0);
    checkRuns("stopped", 1'b0);
    $display("test enable done");
    axiWrite(8'h00, 32'h0003_8200, 4'hF);
    waitBit(9, 1'b0);
    waitBit(8, 1'b1);
    highLen;
    checkWord("divided high", 32'h3, 32'(cnt));
    $display("test divider done");
    axiWrite(8'h00, 32'h0000_A000, 4'hF);
    @(posedge clock);
    idleMode <= 1'b1;
    checkRuns("idle halt", 1'b0);
    axiWrite(8'h00, 32'h0000_8000, 4'hF);
    checkRuns("idle run", 1'b1);
    @(posedge clock);
    idleMode <= 1'b0;
    $display("test idle done");
    axiWrite(8'h00, 32'h0000_8800, 4'hF);
    @(posedge clock);
    sleepMode <= 1'b1;
    checkRuns("sleep source zero", 1'b0);
    axiWrite(8'h00, 32'h0, 4'hF);
    waitBit(8, 1'b0);
    axiWrite(8'h00, 32'h0000_8801, 4'hF);
    waitBit(8, 1'b1);
    checkRuns("sleep run", 1'b1);
    // frozen source: no toggle point, so the new ratio must wait
    @(posedge clock);
    srcRun <= 1'b0;
    repeat (4) @(posedge clock);
    axiWrite(8'h00, 32'h0005_8A01, 4'hF);
    axiRead(8'h00);
    checkWord("pending held", 32'h0005_8B01, rd);
    @(posedge clock);
    srcRun <= 1'b1;
    waitBit(9, 1'b0);
    highLen;
    checkWord("source divided high", 32'h0000_0028, 32'(cnt));
    axiWrite(8'h00, 32'h0000_8001, 4'hF);
    checkRuns("sleep stop", 1'b0);
    $display("test sleep done");
    results;
  end
endmodule
`default_nettype wire
